/* hdl/pss_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer #(
    parameter int SLOTS = 64, // most slots in a cycle
    parameter int SET_W = 32 // width of the sequenceable values
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // acquisition side
    input wire logic frame_trig_i,
    input wire logic line1_i,
    input wire logic line2_i,
    input wire logic [SET_W-1:0] active_i,
    output logic [SET_W-1:0] active_o,
    output logic active_load_o,
    output logic [5:0] cur_slot_o
);
    // how the block behaves, in short:
    // - while off, software programs count, policy, source and slots
    // - a save copies the active values and the staged repeat into a slot
    // - switch-on backs up the active values and loads slot 0
    // - auto policy: a slot serves its repeat count of triggers, then steps
    // - auto policy: the first trigger after switch-on keeps slot 0
    // - controlled policy, always source: a step on every trigger
    // - controlled policy, line sources: a step only with the line high
    // - controlled policy, disabled source: a step only on command
    // - stepping past the last slot of the cycle wraps to slot 0
    // - switch-off stops stepping and puts the backed-up values back
    // limitations worth knowing:
    // - count, policy and source writes are dropped while on, so a
    //   running cycle never sees its length change under it
    // - the save command is dropped while on for the same reason
    // - the repeat register is staged; it only reaches a slot on save
    // - slots never saved since reset read as the default set
    // - a step command and a trigger in one cycle give one step only
    // - the step command is ignored unless the disabled source is chosen
    // - line levels are taken in the trigger cycle, with no filtering
    // - the backup is taken on the switch-on write, so values saved
    //   after that point are lost again at switch-off
    // - only the low six bits of the selector are kept
    // - the use counter in status is meaningful in auto policy only
    // - the status running bit follows the state machine, not the
    //   control register, though both move on the same edge
    // - the load pulse marks every change of the active output,
    //   including the restore at switch-off
    // timing: every answer shows one clock after the edge that
    // takes the request; read data stands for that one cycle only
    // the sequencer never stalls the bus and keeps no buffer
    // beyond the slot memory itself
    // trade-off: slot memory sits in flops with an async reset, which
    // costs area but makes the unsaved-slot default free of any sweep

    // register map, byte offsets:
    // control: bit 0 on, bit 1 policy, bits 3:2 control source
    // count: slots in one cycle, 0 reads back as 1, above 64 as 64
    // select: slot that save and slot-data reads refer to
    // repeat: uses per slot, 1..256, staged until the next save
    // command: bit 0 saves, bit 1 steps; write only, reads zero
    // status: bits 5:0 slot, bit 6 running, bits 15:8 uses so far
    // slot data: stored values of the selected slot
    // reads of unmapped offsets give zero, writes fall on the floor

    // request bundle
    pss_pkg::pss_bus_t bus;
    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // slot storage, one entry per slot
    logic [SET_W-1:0] set_mem [SLOTS];
    logic [7:0] rep_mem [SLOTS]; // repeat count minus one
    logic [SLOTS-1:0] saved_q; // slot written since reset

    // configuration registers
    logic on_q;
    logic policy_q;
    pss_pkg::pss_src_t src_q;
    logic [6:0] count_q;
    logic [5:0] sel_q;
    logic [7:0] rep_q; // stored minus one, so 0 means 1 use
    // run state
    pss_pkg::pss_state_t state_q;
    logic [5:0] slot_q;
    logic [7:0] uses_q;
    logic [SET_W-1:0] backup_q;
    logic [SET_W-1:0] active_q;
    logic load_q;
    logic [31:0] rdata_q;
    // auto policy: the first trigger after switch-on is spent on slot 0
    logic fresh_q;

    // decode of one address into a write hit
    function automatic logic wr_hit(input pss_pkg::pss_bus_t b, input logic [7:0] a);
        wr_hit = b.wr && (b.addr == a);
    endfunction

    // address decode wires, one per writable register
    // control word: on bit, policy and source
    wire w_ctrl = wr_hit(bus, pss_pkg::PSS_REG_CTRL);
    // slots in one cycle
    wire w_count = wr_hit(bus, pss_pkg::PSS_REG_COUNT);
    // slot that a save or slot-data read targets
    wire w_sel = wr_hit(bus, pss_pkg::PSS_REG_SELECT);
    // staged repeat count
    wire w_rep = wr_hit(bus, pss_pkg::PSS_REG_REPEAT);
    // save and step commands
    wire w_cmd = wr_hit(bus, pss_pkg::PSS_REG_CMD);
    // commands only act in the state they belong to
    wire save_cmd = w_cmd && bus.wdata[pss_pkg::PSS_CMD_SAVE_BIT] && !on_q;
    // step request; the source check happens below
    wire sw_step = w_cmd && bus.wdata[pss_pkg::PSS_CMD_STEP_BIT];
    // requested on state
    wire new_on = bus.wdata[pss_pkg::PSS_CTRL_ON_BIT];
    // edges of the on state, seen on the write itself
    wire turn_on = w_ctrl && new_on && !on_q;
    wire turn_off = w_ctrl && !new_on && on_q;
    wire running = (state_q == pss_pkg::PSS_ST_RUN);

    // any bit above the field puts the count over range
    wire count_over = (|bus.wdata[31:7]) || (bus.wdata[6:0] > 7'(SLOTS));
    // clamp the programmed count into 1..64
    wire [6:0] count_clamped =
        (bus.wdata == 32'h00000000) ? 7'h01 :
        count_over ? 7'(SLOTS) : bus.wdata[6:0];
    // repeat count 1..256 held as 0..255
    wire [8:0] rep_in = bus.wdata[8:0];
    // a request above 256 saturates instead of wrapping to a small count
    wire rep_over = (|bus.wdata[31:9]) || (rep_in > 9'h100);
    wire [7:0] rep_clamped =
        (bus.wdata == 32'h00000000) ? 8'h00 :
        rep_over ? 8'hFF : 8'(rep_in - 9'h001);

    // step decision for one trigger or command
    wire line_sel = (src_q == pss_pkg::PSS_SRC_LINE1) ? line1_i : line2_i;
    wire is_line = (src_q == pss_pkg::PSS_SRC_LINE1) || (src_q == pss_pkg::PSS_SRC_LINE2);
    wire auto_trig = running && frame_trig_i && (policy_q == pss_pkg::PSS_POLICY_AUTO);
    // the first auto trigger after switch-on always stays on slot 0
    wire auto_done = !fresh_q && (uses_q >= rep_mem[slot_q]);
    wire ctrl_on = running && (policy_q == pss_pkg::PSS_POLICY_CTRL);
    wire step_always = ctrl_on && frame_trig_i && (src_q == pss_pkg::PSS_SRC_ALWAYS);
    wire step_line = ctrl_on && frame_trig_i && is_line && line_sel;
    wire step_soft = ctrl_on && sw_step && (src_q == pss_pkg::PSS_SRC_OFF);
    wire do_step = (auto_trig && auto_done) || step_always || step_line || step_soft;
    // reuse and step are exclusive by construction
    wire auto_reuse = auto_trig && !auto_done;
    // next slot ascends and wraps at the cycle end
    wire last_slot = ({1'b0, slot_q} >= (count_q - 7'h01));
    wire [5:0] next_slot = last_slot ? 6'h00 : slot_q + 6'h01;

    // slot content, defaults where never saved
    function automatic logic [SET_W-1:0] slot_val(input logic [5:0] s);
        slot_val = saved_q[s] ? set_mem[s] : SET_W'(pss_pkg::PSS_DEFAULT_SET);
    endfunction

    // per-slot storage, written by the save command
    // one save port per slot keeps the write decode local
    // the repeat count travels into the slot with the values
    generate
        for (genvar g = 0; g < SLOTS; g++)
        begin : g_slot
            always_ff @(posedge clk_sys_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    set_mem[g] <= '0;
                    rep_mem[g] <= 8'h00;
                    saved_q[g] <= 1'b0;
                end
                else if (save_cmd && (sel_q == 6'(g)))
                begin
                    set_mem[g] <= active_i; // overwrite old contents
                    rep_mem[g] <= rep_q;
                    saved_q[g] <= 1'b1;
                end
            end
        end
    endgenerate

    // configuration registers; count and policy frozen while on
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            on_q <= 1'b0;
            policy_q <= pss_pkg::PSS_POLICY_AUTO;
            src_q <= pss_pkg::PSS_SRC_ALWAYS;
            count_q <= pss_pkg::PSS_COUNT_RST;
            sel_q <= 6'h00;
            rep_q <= 8'h00;
        end
        else
        begin
            // on bit follows every control write
            if (w_ctrl)
            begin
                on_q <= new_on;
                // mode fields only change while off, protecting a running cycle
                if (!on_q)
                begin
                    policy_q <= bus.wdata[pss_pkg::PSS_CTRL_POLICY_BIT];
                    src_q <= pss_pkg::pss_src_t'(bus.wdata[pss_pkg::PSS_CTRL_SRC_LSB +: 2]);
                end
            end
            // count refused while on
            if (w_count && !on_q)
                count_q <= count_clamped;
            // selector and staged repeat are free at any time
            if (w_sel)
                sel_q <= bus.wdata[5:0];
            if (w_rep)
                rep_q <= rep_clamped;
        end
    end

    // sequencer state and slot stepping
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_q <= pss_pkg::PSS_ST_IDLE;
            slot_q <= 6'h00;
            uses_q <= 8'h00;
            fresh_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                // off: wait for the on bit to rise
                pss_pkg::PSS_ST_IDLE:
                begin
                    if (turn_on)
                    begin
                        state_q <= pss_pkg::PSS_ST_RUN;
                        slot_q <= 6'h00;
                        uses_q <= 8'h00;
                        fresh_q <= 1'b1;
                    end
                end
                // on: step, reuse or stop
                pss_pkg::PSS_ST_RUN:
                begin
                    if (turn_off)
                        state_q <= pss_pkg::PSS_ST_IDLE;
                    else if (do_step)
                    begin
                        // a new slot starts with no uses counted
                        slot_q <= next_slot;
                        uses_q <= 8'h00;
                    end
                    else if (auto_reuse && !fresh_q)
                        uses_q <= uses_q + 8'h01;
                    // the first auto trigger is spent on slot 0 and not counted
                    if (auto_trig)
                        fresh_q <= 1'b0;
                end
                // an illegal code falls back to off
                default:
                    state_q <= pss_pkg::PSS_ST_IDLE;
            endcase
        end
    end

    // active set drive: backup on switch-on, restore on switch-off
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            backup_q <= '0;
            active_q <= '0;
            load_q <= 1'b0;
        end
        else
        begin
            // default: no load this cycle
            load_q <= 1'b0;
            // switch-on: back up, then show slot 0
            if (turn_on && !running)
            begin
                backup_q <= active_i; // values before switch-on
                active_q <= slot_val(6'h00);
                load_q <= 1'b1;
            end
            // switch-off: put the backup back
            else if (running && turn_off)
            begin
                active_q <= backup_q;
                load_q <= 1'b1;
            end
            // step: show the next slot, default if unsaved
            else if (running && do_step)
            begin
                active_q <= slot_val(next_slot);
                load_q <= 1'b1;
            end
        end
    end

    // read mux; unmapped addresses read zero
    // control readback: source, policy, on
    wire [31:0] rd_ctrl = {28'h0, src_q, policy_q, on_q};
    // status: uses so far, running flag, current slot
    wire [31:0] rd_status = {16'h0, uses_q, 1'b0, running, slot_q};
    // count readback, zero-extended
    wire [31:0] rd_count = {25'h0, count_q};
    // selector readback, zero-extended
    wire [31:0] rd_sel = {26'h0, sel_q};
    // staged repeat shown as a count of 1..256
    wire [31:0] rd_rep = {23'h0, 9'({1'b0, rep_q}) + 9'h001};
    // stored values of the selected slot, default if never saved
    wire [31:0] rd_slot = 32'(slot_val(sel_q));
    // the command register is write only and falls to zero here
    wire [31:0] rd_mux =
        (bus.addr == pss_pkg::PSS_REG_CTRL) ? rd_ctrl :
        (bus.addr == pss_pkg::PSS_REG_COUNT) ? rd_count :
        (bus.addr == pss_pkg::PSS_REG_SELECT) ? rd_sel :
        (bus.addr == pss_pkg::PSS_REG_REPEAT) ? rd_rep :
        (bus.addr == pss_pkg::PSS_REG_STATUS) ? rd_status :
        (bus.addr == pss_pkg::PSS_REG_SLOTDATA) ? rd_slot :
        32'h00000000;

    // read data stands one cycle after the strobe only
    // a zero between reads keeps stale data off the bus
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rdata_q <= 32'h00000000;
        else
            rdata_q <= bus.rd ? rd_mux : 32'h00000000;
    end

    // outputs straight from flops
    assign rdata_o = rdata_q;
    assign active_o = active_q;
    assign active_load_o = load_q;
    assign cur_slot_o = slot_q;
endmodule
`default_nettype wire

/* pkg/pss_pkg.sv */
package pss_pkg;
    // register word offsets (byte addresses)
    localparam logic [7:0] PSS_REG_CTRL = 8'h00;
    localparam logic [7:0] PSS_REG_COUNT = 8'h04;
    localparam logic [7:0] PSS_REG_SELECT = 8'h08;
    localparam logic [7:0] PSS_REG_REPEAT = 8'h0C;
    localparam logic [7:0] PSS_REG_CMD = 8'h10;
    localparam logic [7:0] PSS_REG_STATUS = 8'h14;
    localparam logic [7:0] PSS_REG_SLOTDATA = 8'h18;
    // control field positions
    localparam int PSS_CTRL_ON_BIT = 0;
    localparam int PSS_CTRL_POLICY_BIT = 1;
    localparam int PSS_CTRL_SRC_LSB = 2;
    // command field positions
    localparam int PSS_CMD_SAVE_BIT = 0;
    localparam int PSS_CMD_STEP_BIT = 1;
    // reset values
    localparam logic [6:0] PSS_COUNT_RST = 7'h01;
    localparam logic [31:0] PSS_DEFAULT_SET = 32'h00000000;
    // step policy and control source encodings
    localparam logic PSS_POLICY_AUTO = 1'b0;
    localparam logic PSS_POLICY_CTRL = 1'b1;
    typedef enum logic [1:0] {
        PSS_SRC_ALWAYS = 2'h0,
        PSS_SRC_LINE1 = 2'h1,
        PSS_SRC_LINE2 = 2'h2,
        PSS_SRC_OFF = 2'h3
    } pss_src_t;
    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pss_bus_t;
    // sequencer states, one-hot
    typedef enum logic [1:0] {
        PSS_ST_IDLE = 2'b01,
        PSS_ST_RUN = 2'b10
    } pss_state_t;
endpackage

/* dv/pss_trig_model.sv */
`timescale 1ns/1ps
`default_nettype none
// trigger source and input lines facing the camera
module pss_trig_model (
    // clock
    input wire logic clk_sys_i,
    // requests from the bench
    input wire logic fire_i,
    input wire logic [1:0] lvl_i,
    // pins into the sequencer
    output logic trig_o,
    output logic [1:0] line_o
);
    // lines move with the pulse, so they stand before the sampling edge
    always_ff @(posedge clk_sys_i)
    begin
        trig_o <= fire_i;
        line_o <= lvl_i;
    end
endmodule
`default_nettype wire

/* dv/pss_sequencer_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer_sva #(
    parameter int SLOTS = 64,
    parameter int SET_W = 32
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    // acquisition side
    input wire logic frame_trig_i,
    input wire logic line1_i,
    input wire logic line2_i,
    input wire logic [SET_W-1:0] active_i,
    input wire logic [SET_W-1:0] active_o,
    input wire logic active_load_o,
    input wire logic [5:0] cur_slot_o
);
    // shadow of the control state, rebuilt from bus writes
    logic on_q;
    logic pol_q;
    logic [1:0] src_q;
    logic [6:0] cnt_q;
    logic [SET_W-1:0] pre_q;
    logic fresh_q; // no trigger seen since switch-on
    wire ctl_wr = wr_i && addr_i == pss_pkg::PSS_REG_CTRL;
    wire step_wr = wr_i && addr_i == pss_pkg::PSS_REG_CMD && wdata_i[1];
    wire run_ctl = on_q && pol_q && !ctl_wr;
    wire run_auto = on_q && !pol_q && !ctl_wr;
    wire sel_line = src_q == 2'h1 ? line1_i : line2_i;
    wire is_line = src_q == 2'h1 || src_q == 2'h2;
    wire [6:0] cnt_d = wdata_i == 32'h0 ? 7'h01 : wdata_i > 32'h40 ? 7'h40 : wdata_i[6:0];
    wire [6:0] nxt = {1'b0, cur_slot_o} + 7'h01;
    wire [5:0] want = nxt >= cnt_q ? 6'h00 : nxt[5:0];
    // mode and count only move while off, the block refuses them when on
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            {on_q, pol_q, src_q, fresh_q, cnt_q, pre_q} <= {5'h00, 7'h01, {SET_W{1'b0}}};
        else
        begin
            if (ctl_wr) on_q <= wdata_i[0];
            if (ctl_wr && !on_q) {src_q, pol_q} <= wdata_i[3:1];
            if (ctl_wr && !on_q) pre_q <= active_i;
            if (ctl_wr && wdata_i[0] && !on_q) fresh_q <= 1'b1;
            else if (frame_trig_i) fresh_q <= 1'b0;
            if (wr_i && addr_i == pss_pkg::PSS_REG_COUNT && !on_q) cnt_q <= cnt_d;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    a_on_slot0: assert property (ctl_wr && wdata_i[0] && !on_q |=> active_load_o && cur_slot_o == 6'h00)
        else $error("switch-on did not load slot 0");
    a_off_restore: assert property (ctl_wr && !wdata_i[0] && on_q |=> active_load_o && active_o == pre_q)
        else $error("switch-off did not restore saved values");
    a_off_quiet: assert property (!on_q && !ctl_wr |=> !active_load_o)
        else $error("load while off");
    a_always_step: assert property (run_ctl && src_q == 2'h0 && frame_trig_i |=> active_load_o && cur_slot_o == $past(want))
        else $error("always source did not step");
    a_line_hold: assert property (run_ctl && is_line && frame_trig_i && !sel_line |=> !active_load_o && $stable(cur_slot_o))
        else $error("low line moved the slot");
    a_line_step: assert property (run_ctl && is_line && frame_trig_i && sel_line |=> active_load_o && cur_slot_o == $past(want))
        else $error("high line did not step");
    a_step_only: assert property (run_ctl && src_q == 2'h3 && !step_wr |=> !active_load_o)
        else $error("disabled source stepped without command");
    a_auto_trig_only: assert property (run_auto && !frame_trig_i |=> !active_load_o)
        else $error("auto mode loaded without trigger");
    a_auto_first: assert property (run_auto && fresh_q && frame_trig_i |=> !active_load_o)
        else $error("auto first trigger left slot 0");
    c_auto_load: cover property (run_auto && frame_trig_i ##1 active_load_o);
    c_wrap: cover property (on_q && active_load_o && cur_slot_o == 6'h00 && $past(frame_trig_i));
    c_line: cover property (run_ctl && is_line && frame_trig_i && sel_line);
endmodule
bind pss_sequencer pss_sequencer_sva #(.SLOTS(SLOTS), .SET_W(SET_W)) u_sva (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .frame_trig_i(frame_trig_i), .line1_i(line1_i),
    .line2_i(line2_i), .active_i(active_i), .active_o(active_o),
    .active_load_o(active_load_o), .cur_slot_o(cur_slot_o));
`default_nettype wire

/* dv/parameter_set_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module parameter_set_sequencer_tb;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    pss_pkg::pss_bus_t bus = '0; // register request
    logic fire = 1'b0;
    logic [1:0] lvl = 2'h0;
    logic [31:0] act_in = 32'h0;
    logic [31:0] pre = 32'h0;
    logic rd_d = 1'b0;
    wire logic [31:0] rdata_o;
    wire logic [31:0] active_o;
    wire logic active_load_o;
    wire logic [5:0] cur_slot_o;
    wire logic trig;
    wire logic [1:0] line;
    logic [38:0] lq[$]; // expected loads: slot-check flag, slot, value
    logic [31:0] rq[$]; // expected read data
    logic [31:0] val[4];
    logic [38:0] e;
    int fail_count = 0;
    int cmp_count = 0;
    integer seed = 32'hc412;
    pss_sequencer DUT (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(bus.addr),
        .wdata_i(bus.wdata), .wr_i(bus.wr), .rd_i(bus.rd), .rdata_o(rdata_o),
        .frame_trig_i(trig), .line1_i(line[0]), .line2_i(line[1]), .active_i(act_in),
        .active_o(active_o), .active_load_o(active_load_o), .cur_slot_o(cur_slot_o));
    pss_trig_model u_src (.clk_sys_i(clk_sys_i), .fire_i(fire), .lvl_i(lvl), .trig_o(trig),
        .line_o(line));
    initial forever #20 clk_sys_i = ~clk_sys_i;
    task automatic check(input string what, input logic [38:0] exp, input logic [38:0] got);
        cmp_count++;
        if (exp !== got)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one strobe cycle then one idle cycle, so no signal is driven twice per step
    task automatic op(input logic [7:0] a, input logic [31:0] d, input logic w);
        bus <= '{a, d, w, !w};
        @(posedge clk_sys_i);
        bus <= '0;
        @(posedge clk_sys_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rq.push_back(exp);
        op(a, 32'h0, 1'b0);
    endtask
    // one trigger with line levels, then quiet cycles
    task automatic frame(input logic [1:0] lv);
        fire <= 1'b1;
        lvl <= lv;
        @(posedge clk_sys_i);
        fire <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
    endtask
    // results compared as they appear; an unexpected load meets an all-ones note
    always @(posedge clk_sys_i)
    begin
        rd_d <= bus.rd;
        if (rd_d) check("rdata", {7'h0, rq.pop_front()}, {7'h0, rdata_o});
        if (active_load_o === 1'b1)
        begin
            e = lq.size() > 0 ? lq.pop_front() : '1;
            check("load", e, e[38] ? {1'b1, cur_slot_o, active_o} : {1'b0, e[37:32], active_o});
        end
    end
    initial
    begin
        repeat (4000) @(posedge clk_sys_i);
        check("timeout", 39'h0, 39'h1);
        give_verdict();
    end
    initial
    begin
        for (int i = 0; i < 3; i++) val[i] = $random(seed);
        val[3] = pss_pkg::PSS_DEFAULT_SET; // slot 3 left unsaved
        repeat (3) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        rd(pss_pkg::PSS_REG_COUNT, 32'h1);
        rd(8'h20, 32'h0);
        op(pss_pkg::PSS_REG_COUNT, 32'h41, 1'b1);
        rd(pss_pkg::PSS_REG_COUNT, 32'h40);
        op(pss_pkg::PSS_REG_REPEAT, 32'h100, 1'b1);
        rd(pss_pkg::PSS_REG_REPEAT, 32'h100);
        op(pss_pkg::PSS_REG_SELECT, 32'h3F, 1'b1);
        rd(pss_pkg::PSS_REG_SELECT, 32'h3F);
        rd(pss_pkg::PSS_REG_SLOTDATA, 32'h0);
        op(pss_pkg::PSS_REG_COUNT, 32'h4, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            act_in <= val[i];
            op(pss_pkg::PSS_REG_SELECT, 32'(i), 1'b1);
            op(pss_pkg::PSS_REG_REPEAT, i == 1 ? 32'h2 : 32'h1, 1'b1);
            op(pss_pkg::PSS_REG_CMD, 32'h1, 1'b1);
        end
        rd(pss_pkg::PSS_REG_SLOTDATA, val[2]);
        // mode 0 auto, then controlled with each source in turn
        for (int m = 0; m < 5; m++)
        begin
            logic [31:0] cw;
            cw = m == 0 ? 32'h0 : {28'h0, 2'(m - 1), 2'b10};
            pre = $random(seed);
            act_in <= pre;
            op(pss_pkg::PSS_REG_CTRL, cw, 1'b1);
            lq.push_back({1'b1, 6'h0, val[0]});
            op(pss_pkg::PSS_REG_CTRL, cw | 32'h1, 1'b1);
            if (m != 4) op(pss_pkg::PSS_REG_CMD, 32'h2, 1'b1);
            for (int k = 1; k < (m == 0 ? 4 : 5); k++)
            begin
                if (m == 0 && k < 3) frame(2'b11);
                if (m == 2 || m == 3) frame(m == 2 ? 2'b10 : 2'b01);
                if (m == 4) frame(2'b11);
                lq.push_back({1'b1, 6'(k % 4), val[k % 4]});
                if (m == 4) op(pss_pkg::PSS_REG_CMD, 32'h2, 1'b1);
                else frame(m == 3 ? 2'b10 : m == 2 ? 2'b01 : 2'b00);
            end
            lq.push_back({1'b0, 6'h0, pre});
            op(pss_pkg::PSS_REG_CTRL, cw, 1'b1);
            frame(2'b11);
        end
        for (int i = 0; i < 20 && lq.size() > 0; i++) @(posedge clk_sys_i);
        check("pending loads", 39'h0, 39'(lq.size()));
        give_verdict();
    end
endmodule
`default_nettype wire
